/* File: sim/ctp_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ctp_top_chk
  import ctp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pin
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_oe
);
  // control shadow; write data lands one cycle after its address phase
  logic wr_r;
  logic [7:0] wa_r;
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic [2:0] up_r;
  wire logic take = hsel && hready && htrans[1];
  wire logic on_w = c0_r[3];
  wire logic cmp_w = c1_r[7:6] == 2'b00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= 1'b0;
      wa_r <= 8'h00;
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      up_r <= 3'h0;
    end else begin
      wr_r <= take && hwrite;
      wa_r <= haddr[7:0];
      if (wr_r && wa_r == CTP_OFS_CTRL0) begin
        c0_r <= hwdata[7:0];
      end
      if (wr_r && wa_r == CTP_OFS_CTRL1) begin
        c1_r <= hwdata[7:0];
      end
      // internal reset lifts later than rst_n, so outputs are judged after a settle
      if (up_r != 3'h7) begin
        up_r <= up_r + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read not one wait state");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write inserted wait");
  a_ready_pulse: assert property (!hreadyout |=> hreadyout)
    else $error("hreadyout low too long");
  a_hrdata_hold: assert property (up_r == 3'h7 && !$stable(hrdata) |-> !$past(hreadyout))
    else $error("hrdata changed outside read");
  a_oe_mode: assert property (
    (up_r == 3'h7 && $stable(c1_r)) [*2] |-> timer_output_pin_oe == !c1_r[6])
    else $error("pin enable wrong for mode");
  a_pin_idle: assert property (
    (cmp_w && !on_w && $stable(c1_r) && up_r == 3'h7) [*3] |=> $stable(timer_output_pin))
    else $error("pin moved while stopped");
  a_pin_init: assert property (
    $rose(on_w) && cmp_w && !c1_r[2] |-> ##[1:3] timer_output_pin == c1_r[3])
    else $error("pin not set to initial level");
  a_pin_released: assert property (!timer_output_pin_oe |-> !timer_output_pin)
    else $error("pin driven while released");
endmodule : ctp_top_chk
`default_nettype wire

/* File: sim/test_compact_timer_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
module test_compact_timer_pwm
  import ctp_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ext_in = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pin;
  logic pin_oe;
  logic [31:0] rd;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] ra[7] = '{8'h04, 8'h10, 8'h14, 8'h08, 8'h0c, 8'h1c, 8'h00};
  logic [31:0] re[7] = '{32'hff, 32'hff, 32'h3, 32'h0, 32'h0, 32'h0, 32'hff};
  logic [7:0] ac[3] = '{8'h08, 8'h18, 8'h20};
  logic ae[3] = '{1'b1, 1'b0, 1'b1};
  logic [7:0] es[2] = '{8'h68, 8'h78};
  logic [7:0] pc[8] = '{8'ha8, 8'hac, 8'ha0, 8'ha8, 8'h98, 8'h88, 8'haa, 8'ha9};
  logic [9:0] pm[8] = '{10'h20, 10'h20, 10'h20, 10'hc8, 10'h20, 10'h20, 10'h100, 10'h20};
  int ph[8] = '{256, 768, 768, 1024, 1024, 0, 512, 256};
  logic [7:0] kc[4] = '{8'h08, 8'h28, 8'h38, 8'h48};
  int kw[4] = '{160, 640, 2560, 7812};
  logic [7:0] kx[4] = '{8'h28, 8'h28, 8'h28, 8'h02};

  always #4 clk = ~clk;

  ctp_top u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_count_input(ext_in),
    .timer_output_pin(pin), .timer_output_pin_oe(pin_oe));

  // entered just after a rising edge; returns on the edge that ends the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : xfer

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdchk

  // counter goes off first: mode and pin action are unsafe to change while running
  task automatic start(input logic [7:0] c1, input logic [9:0] ma, input logic [7:0] c0);
    xfer(1'b1, CTP_OFS_CTRL0, 32'(c0 & 8'hf7));
    xfer(1'b1, CTP_OFS_MA_LO, 32'(ma[7:0]));
    xfer(1'b1, CTP_OFS_MA_HI, 32'(ma[9:8]));
    xfer(1'b1, CTP_OFS_CTRL1, 32'(c1));
    xfer(1'b1, CTP_OFS_FLAGS, 32'h3);
    xfer(1'b1, CTP_OFS_CTRL0, 32'(c0));
  endtask : start

  // 1024 clocks is a whole number of every period used
  task automatic meas(output int h, output int t);
    logic p;
    h = 0;
    t = 0;
    p = pin;
    repeat (1024) begin
      @(posedge clk);
      h += int'(pin === 1'b1);
      t += int'(pin !== p);
      p = pin;
    end
  endtask : meas

  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #400_000;
    bad_count++;
    print_verdict();
  end

  initial begin
    int h;
    int t;
    logic [31:0] v;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rdchk("reset", 8'(4 * i), 32'h0);
    end
    foreach (ra[i]) begin
      xfer(1'b1, ra[i], 32'hffff_ffff);
      rdchk("reg", ra[i], re[i]);
    end
    chk("oe", 32'h0, 32'(pin_oe));
    start(8'h30, 10'h5, 8'h19);
    repeat (16) @(posedge clk);
    meas(h, t);
    chk("toggles", 32'h8, 32'(t));
    rdchk("flags", CTP_OFS_FLAGS, 32'h3);
    chk("oe", 32'h1, 32'(pin_oe));
    foreach (ac[i]) begin
      start(ac[i], 10'h64, 8'h19);
      repeat (3) @(posedge clk);
      chk("init", 32'(ac[i][3]), 32'(pin));
      repeat (200) @(posedge clk);
      chk("action", 32'(ae[i]), 32'(pin));
    end
    start(8'hf0, 10'h5, 8'h19);
    repeat (300) @(posedge clk);
    rdchk("flags", CTP_OFS_FLAGS, 32'h3);
    chk("oe", 32'h0, 32'(pin_oe));
    start(8'h01, 10'h200, 8'h19);
    repeat (1100) @(posedge clk);
    rdchk("flags", CTP_OFS_FLAGS, 32'h1);
    xfer(1'b0, CTP_OFS_CNT_HI, 32'h0);
    chk("cnt_hi", 32'h0, rd & 32'h2);
    start(8'h01, 10'h0, 8'h19);
    repeat (1100) @(posedge clk);
    rdchk("flags", CTP_OFS_FLAGS, 32'h0);
    xfer(1'b1, CTP_OFS_CTRL0, 32'h99);
    xfer(1'b0, CTP_OFS_CNT_LO, 32'h0);
    v = rd;
    repeat (40) @(posedge clk);
    rdchk("pause", CTP_OFS_CNT_LO, v);
    xfer(1'b1, CTP_OFS_CTRL0, 32'h19);
    xfer(1'b1, CTP_OFS_CTRL0, 32'h11);
    xfer(1'b0, CTP_OFS_CNT_LO, 32'h0);
    chk("resume", 32'h1, 32'((8'(rd - v) - 8'h1) < 8'h8));
    v = rd;
    repeat (40) @(posedge clk);
    rdchk("off", CTP_OFS_CNT_LO, v);
    xfer(1'b1, CTP_OFS_CTRL0, 32'h19);
    xfer(1'b0, CTP_OFS_CNT_LO, 32'h0);
    chk("clear", 32'h1, 32'(rd < 32'h10));
    foreach (es[i]) begin
      start(8'hc0, 10'h0, es[i]);
      repeat (10) begin
        ext_in <= 1'b1;
        repeat (4) @(posedge clk);
        ext_in <= 1'b0;
        repeat (4) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      rdchk("ext", CTP_OFS_CNT_LO, 32'ha);
    end
    // internal sources: count within two of the nominal value
    foreach (kc[i]) begin
      start(8'hc0, 10'h0, kc[i]);
      repeat (kw[i]) @(posedge clk);
      xfer(1'b0, CTP_OFS_CNT_LO, 32'h0);
      chk("prescale", 32'h1, 32'((rd[7:0] - kx[i] + 8'h2) < 8'h5));
    end
    foreach (pc[i]) begin
      start(pc[i], pm[i], 8'h19);
      repeat (16) @(posedge clk);
      meas(h, t);
      chk("pwm_high", 32'(ph[i]), 32'(h));
    end
    rdchk("flags", CTP_OFS_FLAGS, 32'h3);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk("rst_ctrl1", CTP_OFS_CTRL1, 32'h0);
    print_verdict();
  end
endmodule : test_compact_timer_pwm

bind ctp_top ctp_top_chk u_chk (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timer_output_pin(timer_output_pin),
  .timer_output_pin_oe(timer_output_pin_oe)
);
`default_nettype wire

/* File: verilog/ctp_pkg.sv */
package ctp_pkg;

  // byte addresses of the word registers
  localparam logic [7:0] CTP_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] CTP_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] CTP_OFS_CNT_LO = 8'h08;
  localparam logic [7:0] CTP_OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] CTP_OFS_MA_LO = 8'h10;
  localparam logic [7:0] CTP_OFS_MA_HI = 8'h14;
  localparam logic [7:0] CTP_OFS_FLAGS = 8'h18;

  // reset values
  localparam logic [7:0] CTP_RST_CTRL0 = 8'h00;
  localparam logic [7:0] CTP_RST_CTRL1 = 8'h00;
  localparam logic [9:0] CTP_RST_CNT = 10'h000;
  localparam logic [9:0] CTP_RST_MA = 10'h000;
  localparam logic [1:0] CTP_RST_FLAGS = 2'h0;

  // field positions in the flag word
  localparam int CTP_FLAG_A_BIT = 0;
  localparam int CTP_FLAG_P_BIT = 1;

  // counter limits and the step of the compare-P value
  localparam logic [9:0] CTP_CNT_MAX = 10'h3ff;
  localparam int CTP_P_SHIFT = 7;

  // prescaler terminal counts; high clock taken as the system clock
  localparam logic [1:0] CTP_DIV4_LAST = 2'h3;
  localparam logic [5:0] CTP_DIV16_MASK = 6'h0f;
  localparam logic [5:0] CTP_DIV64_LAST = 6'h3f;
  localparam logic [11:0] CTP_SUB_LAST = 12'hf41;

  typedef enum logic [1:0] {
    CTP_MODE_CMP = 2'b00,
    CTP_MODE_UND = 2'b01,
    CTP_MODE_PWM = 2'b10,
    CTP_MODE_TMR = 2'b11
  } ctp_mode_t;

  typedef enum logic [2:0] {
    CTP_CK_SYS4 = 3'b000,
    CTP_CK_SYS = 3'b001,
    CTP_CK_H16 = 3'b010,
    CTP_CK_H64 = 3'b011,
    CTP_CK_SUB0 = 3'b100,
    CTP_CK_SUB1 = 3'b101,
    CTP_CK_EXTR = 3'b110,
    CTP_CK_EXTF = 3'b111
  } ctp_clk_sel_t;

  typedef enum logic [1:0] {
    CTP_ACT_NONE = 2'b00,
    CTP_ACT_LOW = 2'b01,
    CTP_ACT_HIGH = 2'b10,
    CTP_ACT_TOGGLE = 2'b11
  } ctp_action_t;

  typedef struct packed {
    logic counter_pause;
    ctp_clk_sel_t clock_source_select;
    logic counter_on;
    logic [2:0] compare_p_value;
  } ctp_ctrl0_t;

  typedef struct packed {
    ctp_mode_t op_mode_select;
    ctp_action_t pin_action;
    logic output_level_control;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } ctp_ctrl1_t;

endpackage : ctp_pkg

/* File: verilog/ctp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ctp_top
  import ctp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic external_count_input,
  output logic timer_output_pin,
  output logic timer_output_pin_oe
);

  // reset release
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign rst_sync_n = rst_s2_r;

  // register state
  ctp_ctrl0_t ctrl0_r;
  ctp_ctrl1_t ctrl1_r;
  logic [9:0] cnt_r;
  logic [9:0] ma_r;
  logic [7:0] ma_lo_r;
  logic [1:0] ma_hi_r;
  logic [1:0] flags_r;
  logic on_d_r;

  // bus data phase
  logic dph_valid_r;
  logic dph_write_r;
  logic [7:0] dph_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  wire logic accept = hsel & hready & htrans[1];
  wire logic wr_go = dph_valid_r & dph_write_r;
  wire logic rd_go = dph_valid_r & ~dph_write_r & ~hreadyout_r;

  wire logic sel_ctrl0 = (dph_addr_r == CTP_OFS_CTRL0);
  wire logic sel_ctrl1 = (dph_addr_r == CTP_OFS_CTRL1);
  wire logic sel_cnt_lo = (dph_addr_r == CTP_OFS_CNT_LO);
  wire logic sel_cnt_hi = (dph_addr_r == CTP_OFS_CNT_HI);
  wire logic sel_ma_lo = (dph_addr_r == CTP_OFS_MA_LO);
  wire logic sel_ma_hi = (dph_addr_r == CTP_OFS_MA_HI);
  wire logic sel_flags = (dph_addr_r == CTP_OFS_FLAGS);

  wire logic wr_ctrl0 = wr_go & sel_ctrl0;
  wire logic wr_ctrl1 = wr_go & sel_ctrl1;
  wire logic wr_ma_lo = wr_go & sel_ma_lo;
  wire logic wr_ma_hi = wr_go & sel_ma_hi;
  wire logic [1:0] flag_clr = (wr_go & sel_flags) ? hwdata[1:0] : 2'h0;
  wire logic [7:0] wr_byte = hwdata[7:0];

  // count registers have no write decode, writes there are dropped
  wire logic [31:0] rd_ctrl0 = {24'h0, ctrl0_r};
  wire logic [31:0] rd_ctrl1 = {24'h0, ctrl1_r};
  wire logic [31:0] rd_cnt_lo = {24'h0, cnt_r[7:0]};
  wire logic [31:0] rd_cnt_hi = {30'h0, cnt_r[9:8]};
  wire logic [31:0] rd_ma_lo = {24'h0, ma_r[7:0]};
  wire logic [31:0] rd_ma_hi = {30'h0, ma_r[9:8]};
  wire logic [31:0] rd_flags = {30'h0, flags_r};

  // unmapped words read as zero
  wire logic [31:0] rd_mux =
    ({32{sel_ctrl0}} & rd_ctrl0) |
    ({32{sel_ctrl1}} & rd_ctrl1) |
    ({32{sel_cnt_lo}} & rd_cnt_lo) |
    ({32{sel_cnt_hi}} & rd_cnt_hi) |
    ({32{sel_ma_lo}} & rd_ma_lo) |
    ({32{sel_ma_hi}} & rd_ma_hi) |
    ({32{sel_flags}} & rd_flags);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r <= 8'h00;
    end else if (hready) begin
      dph_valid_r <= accept;
      dph_write_r <= hwrite;
      dph_addr_r <= {haddr[7:2], 2'b00};
    end
  end

  // reads take one wait state so the answer comes from a flop
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h0;
      hresp_r <= 1'b0;
    end else if (accept & ~hwrite) begin
      hreadyout_r <= 1'b0;
    end else if (rd_go) begin
      hreadyout_r <= 1'b1;
      hrdata_r <= rd_mux;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl0_r <= ctp_ctrl0_t'(CTP_RST_CTRL0);
    end else if (wr_ctrl0) begin
      ctrl0_r <= ctp_ctrl0_t'(wr_byte);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl1_r <= ctp_ctrl1_t'(CTP_RST_CTRL1);
    end else if (wr_ctrl1) begin
      ctrl1_r <= ctp_ctrl1_t'(wr_byte);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ma_lo_r <= CTP_RST_MA[7:0];
    end else if (wr_ma_lo) begin
      ma_lo_r <= wr_byte;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ma_hi_r <= CTP_RST_MA[9:8];
    end else if (wr_ma_hi) begin
      ma_hi_r <= wr_byte[1:0];
    end
  end

  assign ma_r = {ma_hi_r, ma_lo_r};

  // external count input, two flops then an edge detector
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= external_count_input;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  wire logic ext_rise = ext_s2_r & ~ext_s3_r;
  wire logic ext_fall = ~ext_s2_r & ext_s3_r;

  // prescalers run free so a source switch needs no restart
  logic [1:0] div4_r;
  logic [5:0] div64_r;
  logic [11:0] sub_r;

  wire logic sub_last = (sub_r == CTP_SUB_LAST);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div4_r <= 2'h0;
    end else begin
      div4_r <= div4_r + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div64_r <= 6'h00;
    end else begin
      div64_r <= div64_r + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sub_r <= 12'h000;
    end else begin
      sub_r <= sub_last ? 12'h000 : sub_r + 12'h001;
    end
  end

  // one-cycle strobes of the internal sources
  wire logic tick_sys4 = (div4_r == CTP_DIV4_LAST);
  wire logic tick_h16 = ((div64_r & CTP_DIV16_MASK) == CTP_DIV16_MASK);
  wire logic tick_h64 = (div64_r == CTP_DIV64_LAST);

  logic tick;

  always_comb begin
    unique case (ctrl0_r.clock_source_select)
      CTP_CK_SYS4: tick = tick_sys4;
      CTP_CK_SYS: tick = 1'b1;
      CTP_CK_H16: tick = tick_h16;
      CTP_CK_H64: tick = tick_h64;
      CTP_CK_SUB0: tick = sub_last;
      CTP_CK_SUB1: tick = sub_last;
      CTP_CK_EXTR: tick = ext_rise;
      CTP_CK_EXTF: tick = ext_fall;
    endcase
  end

  // mode decode
  wire logic is_pwm = (ctrl1_r.op_mode_select == CTP_MODE_PWM);
  wire logic is_cmp = (ctrl1_r.op_mode_select == CTP_MODE_CMP);
  wire logic is_tmr = ~is_pwm & ~is_cmp;
  wire logic on_rise = ctrl0_r.counter_on & ~on_d_r;
  wire logic running = ctrl0_r.counter_on & ~ctrl0_r.counter_pause & tick;
  // the held count is stale while the counter restarts, so no flags then
  wire logic step = running & ~on_rise;

  // comparisons look at the value the counter would step to
  wire logic [9:0] cnt_inc = cnt_r + 10'h001;
  wire logic a_hit = (cnt_inc == ma_r);
  wire logic p_hit = (cnt_inc[9:CTP_P_SHIFT] == ctrl0_r.compare_p_value) &
                     (cnt_inc[CTP_P_SHIFT-1:0] == 7'h00);
  wire logic ma_zero = (ma_r == 10'h000);

  // clear sources per mode
  wire logic clr_pwm = ctrl1_r.period_duty_swap ? a_hit : p_hit;
  wire logic clr_cmp = ctrl1_r.clear_source_select ? a_hit : p_hit;
  wire logic clr_hit = is_pwm ? clr_pwm : clr_cmp;

  // flag events
  wire logic a_evt_cmp = a_hit & ~(ctrl1_r.clear_source_select & ma_zero);
  wire logic p_evt_cmp = p_hit & ~ctrl1_r.clear_source_select;
  wire logic a_evt = step & (is_pwm ? a_hit : a_evt_cmp);
  wire logic p_evt = step & (is_pwm ? p_hit : p_evt_cmp);

  logic [9:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (on_rise) begin
      cnt_nxt = CTP_RST_CNT;
    end else if (running) begin
      cnt_nxt = clr_hit ? CTP_RST_CNT : cnt_inc;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_r <= CTP_RST_CNT;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      on_d_r <= 1'b0;
    end else begin
      on_d_r <= ctrl0_r.counter_on;
    end
  end

  // sticky flags; a new event beats a clear in the same cycle
  logic [1:0] flag_set;
  logic [1:0] flags_nxt;

  assign flag_set[CTP_FLAG_A_BIT] = a_evt;
  assign flag_set[CTP_FLAG_P_BIT] = p_evt;

  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags_r <= CTP_RST_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // pwm duty: compare-A, or compare-P code times 128 with 000 meaning 1024
  wire logic p_zero = (ctrl0_r.compare_p_value == 3'h0);
  wire logic [10:0] duty_p = {p_zero, ctrl0_r.compare_p_value, 7'h00};
  wire logic [10:0] duty_a = {1'b0, ma_r};
  wire logic [10:0] duty_val = ctrl1_r.period_duty_swap ? duty_p : duty_a;
  // counter never reaches the period, so duty at or past it stays active
  wire logic pwm_active = ({1'b0, cnt_r} < duty_val);

  logic pwm_sel;

  always_comb begin
    unique case (ctrl1_r.pin_action)
      CTP_ACT_NONE: pwm_sel = 1'b0;
      CTP_ACT_LOW: pwm_sel = 1'b1;
      CTP_ACT_HIGH: pwm_sel = pwm_active;
      CTP_ACT_TOGGLE: pwm_sel = 1'b0;
    endcase
  end

  // active level chosen by output-level control
  wire logic pwm_level = ctrl1_r.output_level_control ? pwm_sel : ~pwm_sel;

  // compare mode pin state before the polarity stage
  logic cmp_pin_r;
  logic cmp_pin_nxt;

  always_comb begin
    cmp_pin_nxt = cmp_pin_r;
    if (on_rise) begin
      cmp_pin_nxt = ctrl1_r.output_level_control;
    end else if (is_cmp & a_evt) begin
      unique case (ctrl1_r.pin_action)
        CTP_ACT_NONE: cmp_pin_nxt = cmp_pin_r;
        CTP_ACT_LOW: cmp_pin_nxt = 1'b0;
        CTP_ACT_HIGH: cmp_pin_nxt = 1'b1;
        CTP_ACT_TOGGLE: cmp_pin_nxt = ~cmp_pin_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmp_pin_r <= 1'b0;
    end else begin
      cmp_pin_r <= cmp_pin_nxt;
    end
  end

  // pin stage; pwm level follows the counter one clock later
  wire logic pin_raw = is_pwm ? pwm_level : cmp_pin_r;
  wire logic pin_nxt = pin_raw ^ ctrl1_r.output_invert;
  logic pin_r;
  logic pin_oe_r;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_r <= is_tmr ? 1'b0 : pin_nxt;
      pin_oe_r <= ~is_tmr;
    end
  end

  assign timer_output_pin = pin_r;
  assign timer_output_pin_oe = pin_oe_r;

  // only whole-word transfers are expected
  wire logic unused_ok = &{1'b0, hsize, haddr[31:8], haddr[1:0], htrans[0], hwdata[31:8]};

endmodule : ctp_top
`default_nettype wire
